//--- rtl/startup_regs.vh
// register offsets, field codes, reset values and timing figures for the start-up sequencer
`ifndef STARTUP_REGS_VH
`define STARTUP_REGS_VH
// register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_VOUT_CMD    12'h008
`define REG_SS_DELAY    12'h00C
`define REG_SS_RAMP     12'h010
`define REG_CEIL_MV     12'h014
`define REG_PINS        12'h018
// control fields
`define CTRL_RESTORE_BIT 0
// pin state codes from the detection front end
`define PIN_LOW         2'h0
`define PIN_OPEN        2'h1
`define PIN_HIGH        2'h2
`define PIN_RES         2'h3
// setpoints in millivolts
`define MV_W            13
`define MV_MIN          13'h0258
`define MV_MAX          13'h1388
`define MV_STRAP_LOW    13'h04B0
`define MV_STRAP_OPEN   13'h05DC
`define MV_STRAP_HIGH   13'h0CE4
// soft-start times in milliseconds
`define MS_W            8
`define SS_STRAP_LOW    8'h02
`define SS_STRAP_OPEN   8'h05
`define SS_STRAP_HIGH   8'h0A
`define PRE_RAMP_MIN_MS 8'h02
// timing
`define CLK_HZ          10000000
`define NVM_TIME_MS     5
`define CYC_PER_MS      ((`CLK_HZ + 999) / 1000)
`endif

//--- rtl/setpoint_decode.v
// decodes a latched voltage-select pin state into a setpoint and ceiling in millivolts
`timescale 1ns/1ns
`include "startup_regs.vh"
module setpoint_decode (
	input wire [1:0] state_i,
	input wire [4:0] res_idx_i,
	output reg [12:0] mv_o,
	output wire [12:0] ceil_o
);
	reg [12:0] res_mv;
	wire [16:0] prod;
	wire [16:0] quot;

	always @* begin
		case (res_idx_i)
			5'h00: res_mv = 13'h0258;
			5'h01: res_mv = 13'h02BC;
			5'h02: res_mv = 13'h02EE;
			5'h03: res_mv = 13'h0320;
			5'h04: res_mv = 13'h0384;
			5'h05: res_mv = 13'h03E8;
			5'h06: res_mv = 13'h044C;
			5'h07: res_mv = 13'h04B0;
			5'h08: res_mv = 13'h04E2;
			5'h09: res_mv = 13'h0514;
			5'h0A: res_mv = 13'h0578;
			5'h0B: res_mv = 13'h05DC;
			5'h0C: res_mv = 13'h0640;
			5'h0D: res_mv = 13'h06A4;
			5'h0E: res_mv = 13'h0708;
			5'h0F: res_mv = 13'h076C;
			5'h10: res_mv = 13'h07D0;
			5'h11: res_mv = 13'h0834;
			5'h12: res_mv = 13'h0898;
			5'h13: res_mv = 13'h08FC;
			5'h14: res_mv = 13'h0960;
			5'h15: res_mv = 13'h09C4;
			5'h16: res_mv = 13'h0A28;
			5'h17: res_mv = 13'h0A8C;
			5'h18: res_mv = 13'h0AF0;
			5'h19: res_mv = 13'h0B54;
			5'h1A: res_mv = 13'h0BB8;
			5'h1B: res_mv = 13'h0C1C;
			5'h1C: res_mv = 13'h0C80;
			5'h1D: res_mv = 13'h0CE4;
			5'h1E: res_mv = 13'h1388;
			// index 31 is not a recognised resistor; fall back to the lowest setpoint
			default: res_mv = `MV_MIN;
		endcase
	end

	always @* begin
		case (state_i)
			`PIN_LOW: mv_o = `MV_STRAP_LOW;
			`PIN_OPEN: mv_o = `MV_STRAP_OPEN;
			`PIN_HIGH: mv_o = `MV_STRAP_HIGH;
			default: mv_o = res_mv;
		endcase
	end

	// ceiling is setpoint plus ten percent, truncated to whole millivolts
	assign prod = {4'h0, mv_o} * 17'h0000B;
	assign quot = prod / 17'h0000A;
	// at most 5500 mV, so the upper quotient bits are always zero
	assign ceil_o = quot[12:0];
endmodule

//--- rtl/startup_sequencer.v
// start-up sequencer with setpoint selection, soft-start delay timing and APB registers
// Contract
// - strap low/open/high gives 1.2/1.5/3.3 V
// - resistor index maps to listed setpoint
// - host may write setpoint 0.6 to 5.0 V
// - power-up runs memory check and load
// - restore command repeats memory check
// - ignore enable and bus while loading
// - sample all configuration pins after load
// - ready only after load and sampling
// - pre-ramp delay is at least 2 ms
// - longer configured delay is honoured fully
// - soft-start pin can extend the delay
// - ramp starts after delay, configured ramp time
// - tied-high enable still waits for initialisation
// - pins sampled only at power-up or restore
// - ceiling is setpoint plus ten percent; code uses the pin-decoded setpoint, not a stored or host-written one
// - soft-start strap gives 2, 5, 10 ms
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "startup_regs.vh"
module startup_sequencer #(
	parameter CYC_PER_MS = `CYC_PER_MS,
	parameter NVM_MS = `NVM_TIME_MS
) (
	input wire CLK_I,
	input wire RST_B_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	input wire ENABLE_I,
	input wire NVM_VALID_I,
	input wire [12:0] NVM_VOUT_MV_I,
	input wire [1:0] VSEL_STATE_I,
	input wire [4:0] VSEL_RES_I,
	input wire [1:0] SS_STATE_I,
	input wire [4:0] SS_RES_I,
	output reg READY_O,
	output reg RAMP_START_O,
	output reg [7:0] RAMP_MS_O,
	output reg [12:0] VOUT_MV_O,
	output reg [12:0] VOUT_CEIL_MV_O
);
	localparam S_NVM = 5'b00001;
	localparam S_PINS = 5'b00010;
	localparam S_READY = 5'b00100;
	localparam S_DELAY = 5'b01000;
	localparam S_RAMP = 5'b10000;

	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg [23:0] tick_r;
	reg [7:0] ms_r;
	reg ms_pulse;
	reg [7:0] wait_ms_r;
	reg [1:0] vsel_st_r;
	reg [4:0] vsel_ix_r;
	reg [12:0] vout_r;
	reg [7:0] ss_delay_r;
	reg [7:0] ss_ramp_r;
	reg restore_r;
	reg [7:0] ss_res_ms;
	reg [7:0] ss_res_ramp;
	reg [7:0] eff_delay;
	wire [12:0] dec_mv;
	wire [12:0] dec_ceil;
	wire busy;
	wire acc;
	wire wr_ok;
	wire wr_ctrl;
	wire wr_vout;
	wire wr_ss_delay;
	wire wr_ss_ramp;
	wire nvm_ok;

	setpoint_decode u_dec (
		.state_i(vsel_st_r),
		.res_idx_i(vsel_ix_r),
		.mv_o(dec_mv),
		.ceil_o(dec_ceil)
	);

	// while busy the access phase stalls and nothing is lost; the host only waits
	assign busy = state_r == S_NVM || state_r == S_PINS;
	assign acc = PSEL_I && PENABLE_I && !busy;
	// a write lands on the completing edge, where the master sees PREADY_O high
	assign wr_ok = acc && PWRITE_I && PREADY_O;
	assign wr_ctrl = wr_ok && PADDR_I == `REG_CTRL;
	assign wr_vout = wr_ok && PADDR_I == `REG_VOUT_CMD;
	assign wr_ss_delay = wr_ok && PADDR_I == `REG_SS_DELAY;
	assign wr_ss_ramp = wr_ok && PADDR_I == `REG_SS_RAMP;

	// stored setpoint counts only when flagged and inside the programmable range
	assign nvm_ok = NVM_VALID_I && NVM_VOUT_MV_I >= `MV_MIN && NVM_VOUT_MV_I <= `MV_MAX;

	// millisecond divider; restarted on every state change so every wait is whole ticks
	always @* begin
		ms_pulse = tick_r == CYC_PER_MS - 1;
	end
	always @(posedge CLK_I) begin
		if (!RST_B_I || state_nxt != state_r) begin
			tick_r <= 24'h000000;
			ms_r <= 8'h00;
		end else if (ms_pulse) begin
			tick_r <= 24'h000000;
			ms_r <= ms_r + 8'h01;
		end else begin
			tick_r <= tick_r + 24'h000001;
		end
	end

	// soft-start resistor table, one entry per recognised resistor, times in ms
	always @* begin
		case (SS_RES_I)
			5'h00: ss_res_ms = 8'h05;
			5'h01: ss_res_ms = 8'h0A;
			5'h02: ss_res_ms = 8'h14;
			5'h03: ss_res_ms = 8'h05;
			5'h04: ss_res_ms = 8'h0A;
			5'h05: ss_res_ms = 8'h14;
			5'h06: ss_res_ms = 8'h05;
			5'h07: ss_res_ms = 8'h0A;
			5'h08: ss_res_ms = 8'h14;
			5'h09: ss_res_ms = 8'h05;
			5'h0A: ss_res_ms = 8'h0A;
			5'h0B: ss_res_ms = 8'h14;
			5'h0C: ss_res_ms = 8'h05;
			5'h0D: ss_res_ms = 8'h0A;
			5'h0E: ss_res_ms = 8'h14;
			5'h0F: ss_res_ms = 8'h05;
			5'h10: ss_res_ms = 8'h0A;
			5'h11: ss_res_ms = 8'h14;
			5'h12: ss_res_ms = 8'h05;
			5'h13: ss_res_ms = 8'h0A;
			5'h14: ss_res_ms = 8'h14;
			5'h15: ss_res_ms = 8'h05;
			5'h16: ss_res_ms = 8'h0A;
			5'h17: ss_res_ms = 8'h14;
			5'h18: ss_res_ms = 8'h05;
			5'h19: ss_res_ms = 8'h0A;
			5'h1A: ss_res_ms = 8'h14;
			5'h1B: ss_res_ms = 8'h05;
			5'h1C: ss_res_ms = 8'h0A;
			5'h1D: ss_res_ms = 8'h14;
			default: ss_res_ms = 8'h05;
		endcase
		// ramp time changes every third resistor
		case (SS_RES_I)
			5'h00: ss_res_ramp = 8'h05;
			5'h01: ss_res_ramp = 8'h05;
			5'h02: ss_res_ramp = 8'h05;
			5'h03: ss_res_ramp = 8'h0A;
			5'h04: ss_res_ramp = 8'h0A;
			5'h05: ss_res_ramp = 8'h0A;
			5'h06: ss_res_ramp = 8'h02;
			5'h07: ss_res_ramp = 8'h02;
			5'h08: ss_res_ramp = 8'h02;
			5'h09: ss_res_ramp = 8'h05;
			5'h0A: ss_res_ramp = 8'h05;
			5'h0B: ss_res_ramp = 8'h05;
			5'h0C: ss_res_ramp = 8'h0A;
			5'h0D: ss_res_ramp = 8'h0A;
			5'h0E: ss_res_ramp = 8'h0A;
			5'h0F: ss_res_ramp = 8'h14;
			5'h10: ss_res_ramp = 8'h14;
			5'h11: ss_res_ramp = 8'h14;
			5'h12: ss_res_ramp = 8'h02;
			5'h13: ss_res_ramp = 8'h02;
			5'h14: ss_res_ramp = 8'h02;
			5'h15: ss_res_ramp = 8'h05;
			5'h16: ss_res_ramp = 8'h05;
			5'h17: ss_res_ramp = 8'h05;
			5'h18: ss_res_ramp = 8'h0A;
			5'h19: ss_res_ramp = 8'h0A;
			5'h1A: ss_res_ramp = 8'h0A;
			5'h1B: ss_res_ramp = 8'h14;
			5'h1C: ss_res_ramp = 8'h14;
			5'h1D: ss_res_ramp = 8'h14;
			default: ss_res_ramp = 8'h14;
		endcase
	end

	always @* begin
		if (ss_delay_r < `PRE_RAMP_MIN_MS)
			eff_delay = `PRE_RAMP_MIN_MS;
		else
			eff_delay = ss_delay_r;
	end

	// a restore outranks every state, so a pending enable cannot ramp on stale settings
	always @* begin
		case (state_r)
			S_NVM: state_nxt = (ms_pulse && ms_r == NVM_MS - 1) ? S_PINS : S_NVM;
			S_PINS: state_nxt = S_READY;
			S_READY: state_nxt = ENABLE_I ? S_DELAY : S_READY;
			S_DELAY: state_nxt = !ENABLE_I ? S_READY :
				((ms_pulse && ms_r == wait_ms_r - 8'h01) ? S_RAMP : S_DELAY);
			S_RAMP: state_nxt = ENABLE_I ? S_RAMP : S_READY;
			default: state_nxt = S_NVM;
		endcase
		if (restore_r)
			state_nxt = S_NVM;
	end

	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			state_r <= S_NVM;
			wait_ms_r <= `PRE_RAMP_MIN_MS;
			vsel_st_r <= `PIN_OPEN;
			vsel_ix_r <= 5'h00;
			vout_r <= `MV_STRAP_OPEN;
			ss_delay_r <= `SS_STRAP_OPEN;
			ss_ramp_r <= `SS_STRAP_OPEN;
			restore_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			restore_r <= wr_ctrl && PWDATA_I[`CTRL_RESTORE_BIT];
			if (state_r == S_NVM && state_nxt == S_PINS && nvm_ok)
				vout_r <= NVM_VOUT_MV_I;
			if (state_r == S_PINS) begin
				vsel_st_r <= VSEL_STATE_I;
				vsel_ix_r <= VSEL_RES_I;
				case (SS_STATE_I)
					`PIN_LOW: begin
						ss_delay_r <= `SS_STRAP_LOW;
						ss_ramp_r <= `SS_STRAP_LOW;
					end
					`PIN_OPEN: begin
						ss_delay_r <= `SS_STRAP_OPEN;
						ss_ramp_r <= `SS_STRAP_OPEN;
					end
					`PIN_HIGH: begin
						ss_delay_r <= `SS_STRAP_HIGH;
						ss_ramp_r <= `SS_STRAP_HIGH;
					end
					default: begin
						ss_delay_r <= ss_res_ms;
						ss_ramp_r <= ss_res_ramp;
					end
				endcase
			end
			// the pin-sampled setpoint overrides memory only when memory held no usable one (nvm_ok low)
			if (state_r == S_PINS && !nvm_ok)
				vout_r <= 13'h0000;
			if (state_r == S_READY && state_nxt == S_DELAY)
				wait_ms_r <= eff_delay;
			if (wr_vout && PWDATA_I[31:13] == 19'h00000 && PWDATA_I[12:0] >= `MV_MIN && PWDATA_I[12:0] <= `MV_MAX)
				vout_r <= PWDATA_I[12:0];
			if (wr_ss_delay)
				ss_delay_r <= PWDATA_I[7:0];
			if (wr_ss_ramp)
				ss_ramp_r <= PWDATA_I[7:0];
		end
	end

	// outputs; a zero vout_r means use the pin decode
	always @(posedge CLK_I) begin
		if (!RST_B_I) begin
			READY_O <= 1'b0;
			RAMP_START_O <= 1'b0;
			RAMP_MS_O <= 8'h00;
			VOUT_MV_O <= 13'h0000;
			VOUT_CEIL_MV_O <= 13'h0000;
			PRDATA_O <= 32'h00000000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			READY_O <= state_r == S_READY || state_r == S_DELAY || state_r == S_RAMP;
			RAMP_START_O <= state_r == S_DELAY && state_nxt == S_RAMP;
			RAMP_MS_O <= ss_ramp_r;
			VOUT_MV_O <= (vout_r == 13'h0000) ? dec_mv : vout_r;
			VOUT_CEIL_MV_O <= dec_ceil;
			PREADY_O <= acc && !PREADY_O;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			if (acc && !PREADY_O && !PWRITE_I) begin
				case (PADDR_I)
					`REG_STATUS: PRDATA_O <= {27'h0000000, state_r};
					`REG_VOUT_CMD: PRDATA_O <= {19'h00000, (vout_r == 13'h0000) ? dec_mv : vout_r};
					`REG_SS_DELAY: PRDATA_O <= {24'h000000, ss_delay_r};
					`REG_SS_RAMP: PRDATA_O <= {24'h000000, ss_ramp_r};
					`REG_CEIL_MV: PRDATA_O <= {19'h00000, dec_ceil};
					`REG_PINS: PRDATA_O <= {18'h00000, SS_RES_I, SS_STATE_I, vsel_ix_r, vsel_st_r};
					`REG_CTRL: PRDATA_O <= 32'h00000000;
					default: PSLVERR_O <= 1'b1;
				endcase
			end else if (acc && !PREADY_O) begin
				case (PADDR_I)
					`REG_CTRL, `REG_VOUT_CMD, `REG_SS_DELAY, `REG_SS_RAMP: PSLVERR_O <= 1'b0;
					default: PSLVERR_O <= 1'b1;
				endcase
			end
		end
	end
endmodule

//--- bench/startup_checker_asserts.sv
// port checks for the start-up sequencer
`timescale 1ns/1ns
module startup_checker #(
	parameter CYC_PER_MS = 10,
	parameter NVM_MS = 5
) (
	input wire CLK_I,
	input wire RST_B_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire ENABLE_I,
	input wire [31:0] PRDATA_O,
	input wire PREADY_O,
	input wire PSLVERR_O,
	input wire READY_O,
	input wire RAMP_START_O
);
	// run lengths: not ready, and enabled while ready
	reg [15:0] lo_r;
	reg [15:0] en_r;
	always @(posedge CLK_I) begin
		lo_r <= (!RST_B_I || READY_O) ? 16'h0000 : lo_r + 16'h0001;
		en_r <= (!RST_B_I || !(ENABLE_I && READY_O)) ? 16'h0000 : en_r + 16'h0001;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_ready_after_load: assert property ($rose(READY_O) |-> lo_r >= CYC_PER_MS * NVM_MS)
		else $error("early ready");
	a_ramp_min_wait: assert property (RAMP_START_O |-> en_r >= 2 * CYC_PER_MS - 1)
		else $error("early ramp");
	a_ramp_single: assert property (RAMP_START_O |=> !RAMP_START_O)
		else $error("long ramp pulse");
	a_ramp_needs_enable: assert property (RAMP_START_O |-> READY_O && $past(ENABLE_I))
		else $error("ramp not enabled");
	a_bus_ignored_busy: assert property (!READY_O && !$past(READY_O) && !$past(READY_O, 2) |-> !PREADY_O)
		else $error("bus answered busy");
	a_ack_after_access: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
		else $error("ack without access");
	a_ack_single: assert property (PREADY_O |=> !PREADY_O)
		else $error("long ack");
	a_err_with_ack: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ack");
	a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("stray read data");
	c_ramp: cover property (RAMP_START_O);
	c_err: cover property (PSLVERR_O);
	c_restore: cover property ($fell(READY_O));
endmodule
bind startup_sequencer startup_checker #(.CYC_PER_MS(CYC_PER_MS), .NVM_MS(NVM_MS)) chk (.CLK_I(CLK_I),
	.RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .ENABLE_I(ENABLE_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .READY_O(READY_O), .RAMP_START_O(RAMP_START_O));

//--- bench/front_end_model.sv
// pin detection front end and stored-setting source
`timescale 1ns/1ns
module front_end_model (
	input wire [5:0] vsel_i,
	input wire [5:0] ss_i,
	input wire [12:0] nvm_i,
	output wire [1:0] vst_o,
	output wire [4:0] vres_o,
	output wire [1:0] sst_o,
	output wire [4:0] sres_o,
	output wire nok_o,
	output wire [12:0] nmv_o
);
	// codes 0..2 are straps, above that a resistor index plus three
	assign vst_o = (vsel_i > 6'h02) ? 2'h3 : vsel_i[1:0];
	assign vres_o = vsel_i[4:0] - 5'h03;
	assign sst_o = (ss_i > 6'h02) ? 2'h3 : ss_i[1:0];
	assign sres_o = ss_i[4:0] - 5'h03;
	// empty memory shows junk so a stale value cannot pass
	assign nok_o = nvm_i != 13'h0000;
	assign nmv_o = nok_o ? nvm_i : 13'h1555;
endmodule

//--- bench/startup_setpoint_sequencer_bench.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/1ns
module startup_setpoint_sequencer_bench;
	localparam CPM = 10;
	reg clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, en = 1'b1, err;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0, rd;
	reg [5:0] vsel = 6'h00, ss = 6'h00;
	reg [12:0] nvm = 13'h0000;
	wire [31:0] prdata;
	wire pready, pslverr, ready, ramp, nok;
	wire [7:0] rms;
	wire [12:0] vout, ceil, nmv;
	wire [1:0] vst, sst;
	wire [4:0] vres, sres;
	integer n_errors = 0, comparisons = 0, cyc = 0, i, k, n, r, t0, e;
	// model: resistor setpoints in 10 mV, strap setpoints and times, ramp per resistor group
	int mv10 [0:30] = '{60, 70, 75, 80, 90, 100, 110, 120, 125, 130, 140, 150, 160, 170, 180, 190, 200, 210,
		220, 230, 240, 250, 260, 270, 280, 290, 300, 310, 320, 330, 500};
	int sv [0:2] = '{1200, 1500, 3300};
	int sd [0:2] = '{2, 5, 10};
	int rg [0:9] = '{5, 10, 2, 5, 10, 20, 2, 5, 10, 20};
	int hv [0:4];
	startup_sequencer #(.CYC_PER_MS(CPM), .NVM_MS(5)) dut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .ENABLE_I(en), .NVM_VALID_I(nok), .NVM_VOUT_MV_I(nmv),
		.VSEL_STATE_I(vst), .VSEL_RES_I(vres), .SS_STATE_I(sst), .SS_RES_I(sres), .READY_O(ready),
		.RAMP_START_O(ramp), .RAMP_MS_O(rms), .VOUT_MV_O(vout), .VOUT_CEIL_MV_O(ceil));
	front_end_model fe (.vsel_i(vsel), .ss_i(ss), .nvm_i(nvm), .vst_o(vst), .vres_o(vres), .sst_o(sst),
		.sres_o(sres), .nok_o(nok), .nmv_o(nmv));
	initial forever #50 clk = ~clk; // stable from time zero, before reset is released
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: timeout", $time);
			print_verdict;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask
	// request held until pready is sampled high
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task restore;
		apb(1'b1, 12'h000, 32'h1);
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (ready === 1'b1);
		while (ready !== 1'b1) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(n >= 5 * CPM && n <= 5 * CPM + 6, 1);
	endtask
	task ramp_wait(input integer d);
		en <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n = n + 1;
		end while (ramp !== 1'b1);
		chk(n >= d * CPM && n <= d * CPM + 3, 1);
		en <= 1'b0;
		@(posedge clk);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		r = $urandom(49155);
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t0 = cyc;
		apb(1'b0, 12'h008, 32'h0);
		chk(cyc - t0 >= 5 * CPM, 1);
		chk(rd, sv[0]);
		while (ramp !== 1'b1) @(posedge clk);
		chk(cyc - t0 >= 7 * CPM, 1);
		en <= 1'b0;
		$display("power-up test done");
		for (i = 0; i < 3; i = i + 1) begin
			vsel <= 6'(i);
			ss <= 6'(i);
			restore;
			vsel <= 6'h08;
			ramp_wait(sd[i]);
			chk(vout, sv[i]);
			chk(ceil, sv[i] * 11 / 10);
			chk(rms, sd[i]);
		end
		$display("strap test done");
		for (i = 0; i < 3; i = i + 1) begin
			r = (i == 0) ? 0 : (i == 1) ? 30 : $urandom % 31;
			k = r % 30;
			vsel <= 6'(r + 3);
			ss <= 6'(k + 3);
			restore;
			chk(vout, mv10[r] * 10);
			chk(ceil, mv10[r] * 11);
			chk(rms, rg[k / 3]);
			ramp_wait(5 << (k % 3));
		end
		$display("resistor test done");
		vsel <= 6'h01;
		nvm <= 13'h09C4;
		restore;
		chk(vout, 2500);
		chk(ceil, 1650);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 1650);
		nvm <= 13'h0000;
		hv = '{600 + $urandom % 4401, 599, 5000, 5001, 600};
		e = 2500;
		for (i = 0; i < 5; i = i + 1) begin
			apb(1'b1, 12'h008, 32'(hv[i]));
			if (hv[i] >= 600 && hv[i] <= 5000)
				e = hv[i];
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, e);
			chk(vout, e);
		end
		apb(1'b1, 12'h00C, 32'h1);
		ramp_wait(2);
		apb(1'b1, 12'h00C, 32'h4);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 4);
		ramp_wait(4);
		apb(1'b0, 12'h020, 32'h0);
		chk(err, 1);
		$display("host test done");
		print_verdict;
	end
endmodule
